// file: design/btcc_ctrl.sv
/*
 * Basic timer, watchdog and system clock select control.
 * Assumes a single oscillator clock and a byte-wide register port on the same clock.
 */
// Functional notes
// - Watchdog disabled only while control bits 7:4 equal 1010.
// - Timer tick is oscillator over 4096, 1024 or 128 per bits 3:2.
// - Writing one to bit 1 clears the basic timer counter.
// - Writing one to bit 0 clears the shared clock dividers.
// - Clear bits return to zero by themselves after the clear.
// - Clock control bits 4:3 select divide by 16, 8, 2 or 1.
// - Reset selects the slowest system clock, divide by 16.
`timescale 1ns/1ps
module btcc_ctrl
    import btcc_pkg::*;
#(
    parameter int CNT_W = 8
)
(
    input wire logic core_clk, // Oscillator clock
    input wire logic resetn, // Async reset, active low
    input wire btcc_pkg::btcc_reg_req_type req, // Register write request
    input wire logic [7:0] rd_addr, // Register read address
    output logic [7:0] rdata, // Register read data
    output logic [CNT_W-1:0] bt_count, // Basic timer counter
    output logic bt_tick, // Basic timer tick pulse
    output logic sys_tick, // System clock enable pulse
    output logic div_clr, // Shared divider clear pulse
    output logic wdt_enabled, // Watchdog enabled level
    output logic wake_irq_off, // Power-down wake-up IRQ disable
    output logic wdt_reset // Watchdog system reset pulse
);
    import btcc_pkg::*;

    logic [7:0] twc_ff;
    logic [1:0] sys_sel_ff;
    logic wake_ff;
    logic [BTCC_DIV_W-1:0] div_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic wdt_reset_ff;
    logic wr_twc;
    logic wr_scc;
    logic tick;

    function automatic logic tap_hit(input logic [BTCC_DIV_W-1:0] d, input int tap);
        logic [BTCC_DIV_W-1:0] m;
        m = BTCC_DIV_W'((1 << tap) - 1);
        return (d & m) == m;
    endfunction

    assign wr_twc = req.wr && (req.addr == BTCC_ADDR_TWC);
    assign wr_scc = req.wr && (req.addr == BTCC_ADDR_SCC);

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            twc_ff <= BTCC_TWC_RESET;
        else if (wr_twc)
            twc_ff <= req.wdata;
        else
        begin
            twc_ff[BTCC_TWC_CNT_CLR] <= 1'b0;
            twc_ff[BTCC_TWC_DIV_CLR] <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sys_sel_ff <= BTCC_SYS_RESET;
            wake_ff <= 1'b0;
        end
        else if (wr_scc)
        begin
            sys_sel_ff <= req.wdata[BTCC_SCC_SEL_HI:BTCC_SCC_SEL_LO];
            wake_ff <= req.wdata[BTCC_SCC_WAKE];
        end
    end

    assign wdt_enabled = (twc_ff[BTCC_TWC_WDT_HI:BTCC_TWC_WDT_LO] != BTCC_WDT_OFF_CODE);
    assign div_clr = twc_ff[BTCC_TWC_DIV_CLR];
    assign wake_irq_off = wake_ff;

    // ------------------------------------------------------------
    // Prescaler and tick select
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            div_ff <= '0;
        else if (div_clr)
            div_ff <= '0;
        else
            div_ff <= div_ff + 1'b1;
    end

    always_comb
    begin
        case (twc_ff[BTCC_TWC_SEL_HI:BTCC_TWC_SEL_LO])
            2'h0: tick = tap_hit(div_ff, BTCC_TAP_4096);
            2'h1: tick = tap_hit(div_ff, BTCC_TAP_1024);
            2'h2: tick = tap_hit(div_ff, BTCC_TAP_128);
            default: tick = 1'b0;
        endcase
    end
    assign bt_tick = tick && !div_clr;

    // ------------------------------------------------------------
    // Basic timer counter and watchdog
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            cnt_ff <= '0;
        else if (twc_ff[BTCC_TWC_CNT_CLR])
            cnt_ff <= '0;
        else if (bt_tick)
            cnt_ff <= cnt_ff + 1'b1;
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            wdt_reset_ff <= 1'b0;
        else
            wdt_reset_ff <= wdt_enabled && bt_tick && !twc_ff[BTCC_TWC_CNT_CLR] && (&cnt_ff);
    end
    assign wdt_reset = wdt_reset_ff;
    assign bt_count = cnt_ff;

    always_comb
    begin
        case (rd_addr)
            BTCC_ADDR_TWC: rdata = twc_ff;
            BTCC_ADDR_SCC: rdata = {wake_ff, 2'h0, sys_sel_ff, 3'h0};
            default: rdata = 8'h00;
        endcase
    end

    btcc_sysclk_div u_sysdiv (
        .core_clk(core_clk),
        .resetn(resetn),
        .div_clr(div_clr),
        .sel(sys_sel_ff),
        .sys_tick(sys_tick)
    );

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_wdt_code;
        @(posedge core_clk) disable iff (!resetn)
        (twc_ff[7:4] == 4'hA) |-> !wdt_enabled;
    endproperty
    a_wdt_code: assert property (p_wdt_code) else $error("watchdog enabled under off code");

    property p_sel_inv;
        @(posedge core_clk) disable iff (!resetn)
        (twc_ff[3:2] == 2'h3) |-> !bt_tick;
    endproperty
    a_sel_inv: assert property (p_sel_inv) else $error("tick under invalid select");

    property p_cnt_clr;
        @(posedge core_clk) disable iff (!resetn)
        wr_twc && req.wdata[1] |=> ##1 (cnt_ff == '0);
    endproperty
    a_cnt_clr: assert property (p_cnt_clr) else $error("counter not cleared");

    property p_div_clr;
        @(posedge core_clk) disable iff (!resetn)
        wr_twc && req.wdata[0] |=> ##1 (div_ff == '0);
    endproperty
    a_div_clr: assert property (p_div_clr) else $error("divider not cleared");

    property p_self_clr;
        @(posedge core_clk) disable iff (!resetn)
        (twc_ff[1] || twc_ff[0]) && !wr_twc |=> (twc_ff[1:0] == 2'h0);
    endproperty
    a_self_clr: assert property (p_self_clr) else $error("clear bit stuck");

    property p_div16;
        @(posedge core_clk) disable iff (!resetn)
        (sys_sel_ff == 2'h0) && sys_tick && !div_clr |=> (!sys_tick || (sys_sel_ff != 2'h0)) [*8];
    endproperty
    a_div16: assert property (p_div16) else $error("divide by 16 too fast");

    property p_div1;
        @(posedge core_clk) disable iff (!resetn)
        (sys_sel_ff == 2'h3) |-> sys_tick;
    endproperty
    a_div1: assert property (p_div1) else $error("undivided clock missing");

    property p_rst_sel;
        @(posedge core_clk)
        $rose(resetn) |-> (sys_sel_ff == 2'h0);
    endproperty
    a_rst_sel: assert property (p_rst_sel) else $error("reset select not slowest");

    property p_wdt_fire;
        @(posedge core_clk) disable iff (!resetn)
        wdt_reset |-> $past(wdt_enabled) && ($past(cnt_ff) == {CNT_W{1'b1}});
    endproperty
    a_wdt_fire: assert property (p_wdt_fire) else $error("spurious watchdog reset");

    property p_bt_inc;
        @(posedge core_clk) disable iff (!resetn)
        wdt_enabled && bt_tick && !twc_ff[BTCC_TWC_CNT_CLR] |=> (cnt_ff == CNT_W'($past(cnt_ff) + 1'b1));
    endproperty
    a_bt_inc: assert property (p_bt_inc) else $error("counter missed a tick");

    property p_wdt_off;
        @(posedge core_clk) disable iff (!resetn)
        !wdt_enabled |=> !wdt_reset;
    endproperty
    a_wdt_off: assert property (p_wdt_off) else $error("watchdog reset while disabled");

    c_wdt_reset: cover property (@(posedge core_clk) disable iff (!resetn) wdt_reset);
    c_cnt_clear: cover property (@(posedge core_clk) disable iff (!resetn) wr_twc && req.wdata[1]);
    c_sys_div8: cover property (@(posedge core_clk) disable iff (!resetn) (sys_sel_ff == 2'h1) && sys_tick);
    c_wdt_off_tick: cover property (@(posedge core_clk) disable iff (!resetn) !wdt_enabled && bt_tick);
    c_div_clear: cover property (@(posedge core_clk) disable iff (!resetn) div_clr);
endmodule // btcc_ctrl

// file: design/btcc_pkg.sv
/*
 * Package for the basic timer, watchdog and system clock control block.
 * Assumes an 8-bit register port with address, write strobe and write data.
 */
package btcc_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] BTCC_ADDR_TWC = 8'hD3;
    localparam logic [7:0] BTCC_ADDR_SCC = 8'hD4;
    localparam logic [7:0] BTCC_TWC_RESET = 8'h00;
    localparam logic [3:0] BTCC_WDT_OFF_CODE = 4'hA;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BTCC_TWC_WDT_HI = 7;
    localparam int BTCC_TWC_WDT_LO = 4;
    localparam int BTCC_TWC_SEL_HI = 3;
    localparam int BTCC_TWC_SEL_LO = 2;
    localparam int BTCC_TWC_CNT_CLR = 1;
    localparam int BTCC_TWC_DIV_CLR = 0;
    localparam int BTCC_SCC_WAKE = 7;
    localparam int BTCC_SCC_SEL_HI = 4;
    localparam int BTCC_SCC_SEL_LO = 3;
    // ------------------------------------------------------------
    // Divider taps: tick period is 2**tap
    // ------------------------------------------------------------
    localparam int BTCC_DIV_W = 12;
    localparam int BTCC_TAP_4096 = 12;
    localparam int BTCC_TAP_1024 = 10;
    localparam int BTCC_TAP_128 = 7;
    localparam logic [1:0] BTCC_SYS_DIV16 = 2'h0;
    localparam logic [1:0] BTCC_SYS_DIV8 = 2'h1;
    localparam logic [1:0] BTCC_SYS_DIV2 = 2'h2;
    localparam logic [1:0] BTCC_SYS_DIV1 = 2'h3;
    localparam logic [1:0] BTCC_SYS_RESET = BTCC_SYS_DIV16;

    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } btcc_reg_req_type;
endpackage

// file: design/btcc_sysclk_div.sv
/*
 * System clock enable generator: one pulse every 16, 8, 2 or 1 oscillator cycles.
 * Assumes the divider clear comes from the control block on the same clock.
 */
`timescale 1ns/1ps
module btcc_sysclk_div
    import btcc_pkg::*;
(
    input wire logic core_clk, // Oscillator clock
    input wire logic resetn, // Async reset, active low
    input wire logic div_clr, // Clear prescaler
    input wire logic [1:0] sel, // Divide select
    output logic sys_tick // System clock enable pulse
);
    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;
    logic [3:0] mask;

    always_comb
    begin
        case (sel)
            BTCC_SYS_DIV16: mask = 4'hF;
            BTCC_SYS_DIV8: mask = 4'h7;
            BTCC_SYS_DIV2: mask = 4'h1;
            default: mask = 4'h0;
        endcase
    end

    assign nxt_cnt = div_clr ? 4'h0 : cnt_ff + 4'h1;
    assign sys_tick = ((cnt_ff & mask) == mask);

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            cnt_ff <= 4'h0;
        else
            cnt_ff <= nxt_cnt;
    end
endmodule // btcc_sysclk_div

// file: tb/btcc_testbench.sv
/*
 * Self-checking bench for the basic timer, watchdog and system clock control.
 * Assumes btcc_ctrl as the DUT under this bench with CNT_W shortened to 3 and assertions inside the design.
 */
`timescale 1ns/1ps
module testbench;
    import btcc_pkg::*;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    btcc_reg_req_type req = '0;
    logic [7:0] rd_addr = 8'h00;
    logic [7:0] rdata;
    logic [2:0] bt_count;
    logic bt_tick;
    logic sys_tick;
    logic div_clr;
    logic wdt_enabled;
    logic wake_irq_off;
    logic wdt_reset;
    int n_errors = 0;
    int n_checks = 0;
    logic [7:0] rv;
    logic [15:0] cnt;
    int n;

    btcc_ctrl #(.CNT_W(3)) dut (.core_clk(core_clk), .resetn(resetn), .req(req), .rd_addr(rd_addr),
        .rdata(rdata), .bt_count(bt_count), .bt_tick(bt_tick), .sys_tick(sys_tick), .div_clr(div_clr),
        .wdt_enabled(wdt_enabled), .wake_irq_off(wake_irq_off), .wdt_reset(wdt_reset));

    always #4 core_clk = ~core_clk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        req <= '{wr: 1'b1, addr: a, wdata: d};
        @(negedge core_clk);
        req <= '0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        rd_addr = a;
        @(negedge core_clk);
        d = rdata;
    endtask

    // Counts one-cycle pulses: 0 timer tick, 1 system tick, 2 watchdog reset
    task automatic count(input int which, input int cycles, output logic [15:0] c);
        c = '0;
        repeat (cycles)
        begin
            @(negedge core_clk);
            c += (which == 0) ? bt_tick : (which == 1) ? sys_tick : wdt_reset;
        end
    endtask

    task automatic close_out;
        if (n_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rd(BTCC_ADDR_TWC, rv);
        chk("twc reset", 16'h0000, {8'h00, rv});
        rd(BTCC_ADDR_SCC, rv);
        chk("scc reset", 16'h0000, {8'h00, rv});
        rd(8'h55, rv);
        chk("unmapped read", 16'h0000, {8'h00, rv});
        chk("wdt enabled at reset", 16'h0001, {15'h0000, wdt_enabled});
        count(1, 32, cnt);
        chk("reset sysclk ticks", 16'h0002, cnt);
    endtask

    task automatic t_sysclk;
        int per[4] = '{16, 8, 2, 1};
        for (int k = 0; k < 4; k++)
        begin
            wr(BTCC_ADDR_SCC, 8'(k << 3));
            count(1, 32, cnt);
            chk("sysclk ticks", 16'(32 / per[k]), cnt);
        end
        wr(BTCC_ADDR_SCC, 8'h80);
        rd(BTCC_ADDR_SCC, rv);
        chk("scc wake bit", 16'h0180, {7'h00, wake_irq_off, rv});
        wr(BTCC_ADDR_SCC, 8'h00);
    endtask

    task automatic t_wdt_code;
        for (int k = 0; k < 16; k++)
        begin
            wr(BTCC_ADDR_TWC, 8'(k << 4));
            chk("wdt enable per code", 16'(k != 10), {15'h0000, wdt_enabled});
        end
    endtask

    task automatic t_btsel;
        int per[4] = '{4096, 1024, 128, 256};
        for (int k = 0; k < 4; k++)
        begin
            wr(BTCC_ADDR_TWC, 8'hA1 | 8'(k << 2));
            count(0, 2 * per[k], cnt);
            chk("timer ticks", (k == 3) ? 16'h0000 : 16'h0002, cnt);
        end
    endtask

    task automatic t_clear;
        wr(BTCC_ADDR_TWC, 8'hAB);
        count(0, 300, cnt);
        chk("counter after two ticks", 16'h0002, {13'h0000, bt_count});
        wr(BTCC_ADDR_TWC, 8'hAA);
        @(negedge core_clk);
        chk("counter cleared", 16'h0000, {13'h0000, bt_count});
        rd(BTCC_ADDR_TWC, rv);
        chk("count clear bit self-clears", 16'h00A8, {8'h00, rv});
        wr(BTCC_ADDR_TWC, 8'hA9);
        chk("divider clear pulse", 16'h0001, {15'h0000, div_clr});
        @(negedge core_clk);
        rd(BTCC_ADDR_TWC, rv);
        chk("divider clear bit self-clears", 16'h00A8, {7'h00, div_clr, rv});
        count(0, 100, cnt);
        chk("no tick after divider clear", 16'h0000, cnt);
    endtask

    task automatic t_wdt;
        wr(BTCC_ADDR_TWC, 8'h0B);
        n = 0;
        while (wdt_reset !== 1'b1 && n < 1200)
        begin
            @(negedge core_clk);
            n++;
        end
        chk("wdt overflow delay in range", 16'h0001, {15'h0000, n >= 1000 && n <= 1040});
        wr(BTCC_ADDR_TWC, 8'hAB);
        count(2, 1200, cnt);
        chk("no wdt reset when disabled", 16'h0000, cnt);
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        repeat (8) @(negedge core_clk);
        resetn = 1'b1;
        t_reset();
        t_sysclk();
        t_wdt_code();
        t_btsel();
        t_clear();
        t_wdt();
        close_out();
    end

    initial
    begin
        repeat (25000) @(posedge core_clk);
        n_errors++;
        close_out();
    end
endmodule // testbench
